// [rtl/ccs_pkg.sv]
package ccs_pkg;
  localparam int ADDR_W = 16;
  localparam int IDX_W = 14;
  localparam int DATA_W = 32;
  localparam int ACC_W = 8;
  localparam int BANK_W = 6;
  localparam int PCL_W = 7;
  localparam int PTR_W = 16;
  localparam int FLAG_W = 5;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FLAGS = 14'h1FE4;
  localparam logic [IDX_W-1:0] IDX_ACC = 14'h1FE5;
  localparam logic [IDX_W-1:0] IDX_BANK = 14'h1FE6;
  localparam logic [IDX_W-1:0] IDX_PCL = 14'h1FE7;
  localparam logic [IDX_W-1:0] IDX_PTR0 = 14'h1FE8;
  localparam logic [IDX_W-1:0] IDX_PTR0_HI = 14'h1FE9;
  localparam logic [IDX_W-1:0] IDX_PTR1 = 14'h1FEA;
  localparam logic [IDX_W-1:0] IDX_PTR1_HI = 14'h1FEB;
  // flag field positions
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_POWER_DOWN = 3;
  localparam int BIT_Z = 2;
  localparam int BIT_HALF_CARRY = 1;
  localparam int BIT_C = 0;
  localparam int BIT_NIB = 3;
  // live flags after power-up: timeout and power-down set
  localparam logic [FLAG_W-1:0] FLAGS_PUP = 5'h18;
  typedef enum logic [2:0] {
    CCS_OP_ADD_REG = 3'h0,
    CCS_OP_ADD_LIT = 3'h1,
    CCS_OP_SUB_LIT = 3'h2,
    CCS_OP_SUB_REG = 3'h3,
    CCS_OP_RRC = 3'h4,
    CCS_OP_RLC = 3'h5,
    CCS_OP_LOGIC = 3'h6,
    CCS_OP_NONE = 3'h7
  } ccs_op_e;
endpackage : ccs_pkg

// [rtl/ccs_flag_unit.sv]
`timescale 1ns/1ns
// flag arithmetic for one core operation, purely combinational
module ccs_flag_unit (
  input wire ccs_pkg::ccs_op_e op,
  input wire logic [ccs_pkg::ACC_W-1:0] a,
  input wire logic [ccs_pkg::ACC_W-1:0] b,
  input wire logic c_in,
  output logic [ccs_pkg::ACC_W-1:0] res,
  output logic z,
  output logic hc,
  output logic c,
  output logic upd_z,
  output logic upd_carry,
  output logic upd_c
);
  import ccs_pkg::*;
  logic [ACC_W-1:0] opnd;
  logic [ACC_W:0] sum;
  logic [4:0] nib;
  logic is_sub;

  // subtraction reuses the adder with the inverted operand and carry in
  assign is_sub = (op == CCS_OP_SUB_LIT) || (op == CCS_OP_SUB_REG);
  assign opnd = is_sub ? ~b : b;
  assign sum = {1'b0, a} + {1'b0, opnd} + {{ACC_W{1'b0}}, is_sub};
  assign nib = {1'b0, a[BIT_NIB:0]} + {1'b0, opnd[BIT_NIB:0]} + {4'h0, is_sub};

  // pick result and flag updates per operation
  always_comb begin
    res = sum[ACC_W-1:0];
    hc = nib[4];
    c = sum[ACC_W];
    upd_z = 1'b0;
    upd_carry = 1'b0;
    upd_c = 1'b0;
    case (op)
      CCS_OP_ADD_REG, CCS_OP_ADD_LIT, CCS_OP_SUB_LIT, CCS_OP_SUB_REG: begin
        upd_z = 1'b1;
        upd_carry = 1'b1;
      end
      CCS_OP_RRC: begin
        res = {c_in, a[ACC_W-1:1]};
        c = a[0];
        upd_c = 1'b1;
      end
      CCS_OP_RLC: begin
        res = {a[ACC_W-2:0], c_in};
        c = a[ACC_W-1];
        upd_c = 1'b1;
      end
      CCS_OP_LOGIC: begin
        res = b; // logic result is computed by the core
        upd_z = 1'b1;
      end
      default: begin
        res = a;
      end
    endcase
    z = (res == {ACC_W{1'b0}});
  end
endmodule : ccs_flag_unit

// [rtl/ccs_bank.sv]
// Local design decision: the APB slave port.
`timescale 1ns/1ns
// shadow copies of the core context, reachable over apb
module ccs_bank (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ccs_pkg::ADDR_W-1:0] paddr,
  input wire logic [ccs_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [ccs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // core events
  input wire ccs_pkg::ccs_op_e alu_op,
  input wire logic [ccs_pkg::ACC_W-1:0] alu_a,
  input wire logic [ccs_pkg::ACC_W-1:0] alu_b,
  input wire logic wdt_clear,
  input wire logic sleep_instr,
  input wire logic wdt_timeout,
  // context save on interrupt entry
  input wire logic core_save,
  input wire logic [ccs_pkg::ACC_W-1:0] core_acc,
  input wire logic [ccs_pkg::BANK_W-1:0] core_bank,
  input wire logic [ccs_pkg::PCL_W-1:0] core_pcl,
  input wire logic [ccs_pkg::PTR_W-1:0] core_ptr0,
  input wire logic [ccs_pkg::PTR_W-1:0] core_ptr1,
  // context restore on interrupt return
  input wire logic core_restore,
  output logic restore_valid,
  output logic [ccs_pkg::ACC_W-1:0] restore_acc,
  output logic [ccs_pkg::BANK_W-1:0] restore_bank,
  output logic [ccs_pkg::PCL_W-1:0] restore_pcl,
  output logic [ccs_pkg::PTR_W-1:0] restore_ptr0,
  output logic [ccs_pkg::PTR_W-1:0] restore_ptr1,
  output logic [ccs_pkg::FLAG_W-1:0] live_flags,
  output logic [ccs_pkg::ACC_W-1:0] alu_result
);
  import ccs_pkg::*;

  logic [FLAG_W-1:0] live_q;
  logic [FLAG_W-1:0] flags_cp_q;
  logic [ACC_W-1:0] acc_cp_q;
  logic [BANK_W-1:0] bank_cp_q;
  logic [PCL_W-1:0] pcl_cp_q;
  logic [PTR_W-1:0] ptr0_cp_q;
  logic [PTR_W-1:0] ptr1_cp_q;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] rd_d;
  logic restore_q;
  logic [ACC_W-1:0] res_q;
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic hit;
  logic wr_en;
  logic rd_setup;
  logic [ACC_W-1:0] fu_res;
  logic fu_z;
  logic fu_hc;
  logic fu_c;
  logic fu_upd_z;
  logic fu_upd_carry;
  logic fu_upd_c;

  // decoding used by both the read mux and the write strobes
  function automatic logic is_mapped(input logic [IDX_W-1:0] i);
    is_mapped = (i >= IDX_FLAGS) && (i <= IDX_PTR1_HI);
  endfunction : is_mapped

  // flag arithmetic
  ccs_flag_unit u_flags (
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .c_in(live_q[BIT_C]),
    .res(fu_res),
    .z(fu_z),
    .hc(fu_hc),
    .c(fu_c),
    .upd_z(fu_upd_z),
    .upd_carry(fu_upd_carry),
    .upd_c(fu_upd_c)
  );

  // address decode; zero wait states so pready is constant
  assign idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit = aligned && is_mapped(idx);
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit; // unmapped or misaligned
  assign prdata = prdata_q;

  // live flags; timeout beats watchdog-clear beats sleep when they collide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live_q <= FLAGS_PUP;
    end else begin
      if (wdt_timeout) begin
        live_q[BIT_TIMEOUT] <= 1'b0;
      end else if (wdt_clear) begin
        live_q[BIT_TIMEOUT] <= 1'b1;
        live_q[BIT_POWER_DOWN] <= 1'b1;
      end else if (sleep_instr) begin
        live_q[BIT_TIMEOUT] <= 1'b1;
        live_q[BIT_POWER_DOWN] <= 1'b0;
      end
      if (core_restore) begin
        live_q[BIT_Z] <= flags_cp_q[BIT_Z];
        live_q[BIT_HALF_CARRY] <= flags_cp_q[BIT_HALF_CARRY];
        live_q[BIT_C] <= flags_cp_q[BIT_C];
      end else begin
        if (fu_upd_z) begin
          live_q[BIT_Z] <= fu_z;
        end
        if (fu_upd_carry) begin
          live_q[BIT_HALF_CARRY] <= fu_hc;
          live_q[BIT_C] <= fu_c;
        end else if (fu_upd_c) begin
          live_q[BIT_C] <= fu_c;
        end
      end
    end
  end

  // result of the last operation, handed back to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= 8'h00;
    end else if (alu_op != CCS_OP_NONE) begin
      res_q <= fu_res;
    end
  end

  // flag copy; no reset so only power loss leaves it undefined
  // a capture by the core wins over a software write in the same cycle
  always_ff @(posedge pclk) begin
    if (core_save) begin
      flags_cp_q <= live_q;
    end else if (wr_en && idx == IDX_FLAGS && pstrb[0]) begin
      flags_cp_q[BIT_Z] <= pwdata[BIT_Z];
      flags_cp_q[BIT_HALF_CARRY] <= pwdata[BIT_HALF_CARRY];
      flags_cp_q[BIT_C] <= pwdata[BIT_C]; // timeout and power-down stay
    end
  end

  // accumulator, bank and latch copies, unchanged by presetn
  always_ff @(posedge pclk) begin
    if (core_save) begin
      acc_cp_q <= core_acc;
      bank_cp_q <= core_bank;
      pcl_cp_q <= core_pcl;
    end else if (wr_en && pstrb[0]) begin
      if (idx == IDX_ACC) begin
        acc_cp_q <= pwdata[ACC_W-1:0];
      end else if (idx == IDX_BANK) begin
        bank_cp_q <= pwdata[BANK_W-1:0];
      end else if (idx == IDX_PCL) begin
        pcl_cp_q <= pwdata[PCL_W-1:0];
      end
    end
  end

  // pointer copies: full word at the base index, high byte alone above it
  always_ff @(posedge pclk) begin
    if (core_save) begin
      ptr0_cp_q <= core_ptr0;
      ptr1_cp_q <= core_ptr1;
    end else if (wr_en) begin
      if (idx == IDX_PTR0) begin
        if (pstrb[0]) begin
          ptr0_cp_q[7:0] <= pwdata[7:0];
        end
        if (pstrb[1]) begin
          ptr0_cp_q[15:8] <= pwdata[15:8];
        end
      end else if (idx == IDX_PTR0_HI && pstrb[0]) begin
        ptr0_cp_q[15:8] <= pwdata[7:0];
      end else if (idx == IDX_PTR1) begin
        if (pstrb[0]) begin
          ptr1_cp_q[7:0] <= pwdata[7:0];
        end
        if (pstrb[1]) begin
          ptr1_cp_q[15:8] <= pwdata[15:8];
        end
      end else if (idx == IDX_PTR1_HI && pstrb[0]) begin
        ptr1_cp_q[15:8] <= pwdata[7:0];
      end
    end
  end

  // read mux; unimplemented bits and unmapped reads give zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (!hit) begin
      rd_d = 32'h0000_0000;
    end else if (idx == IDX_FLAGS) begin
      rd_d[FLAG_W-1:0] = flags_cp_q;
    end else if (idx == IDX_ACC) begin
      rd_d[ACC_W-1:0] = acc_cp_q;
    end else if (idx == IDX_BANK) begin
      rd_d[BANK_W-1:0] = bank_cp_q;
    end else if (idx == IDX_PCL) begin
      rd_d[PCL_W-1:0] = pcl_cp_q;
    end else if (idx == IDX_PTR0) begin
      rd_d[PTR_W-1:0] = ptr0_cp_q;
    end else if (idx == IDX_PTR0_HI) begin
      rd_d[7:0] = ptr0_cp_q[15:8];
    end else if (idx == IDX_PTR1) begin
      rd_d[PTR_W-1:0] = ptr1_cp_q;
    end else begin
      rd_d[7:0] = ptr1_cp_q[15:8];
    end
  end

  // read data is latched in the setup phase so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= rd_d;
    end
  end

  // restore strobe follows the request by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_q <= 1'b0;
    end else begin
      restore_q <= core_restore;
    end
  end

  // the core drives its bank from restore_bank for direct accesses;
  // pointers carry full 16-bit addresses so every bank stays reachable
  assign restore_valid = restore_q;
  assign restore_acc = acc_cp_q;
  assign restore_bank = bank_cp_q;
  assign restore_pcl = pcl_cp_q;
  assign restore_ptr0 = ptr0_cp_q;
  assign restore_ptr1 = ptr1_cp_q;
  assign live_flags = live_q;
  assign alu_result = res_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_timeout_clr;
    wdt_timeout |=> !live_q[BIT_TIMEOUT];
  endproperty
  a_timeout_clr: assert property (p_timeout_clr) else $error("timeout flag not cleared");

  property p_sleep_pwr;
    sleep_instr && !wdt_clear && !wdt_timeout |=> live_q[BIT_TIMEOUT] && !live_q[BIT_POWER_DOWN];
  endproperty
  a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep did not clear power-down");

  property p_ro_bits;
    wr_en && idx == IDX_FLAGS && !core_save |=> $stable(flags_cp_q[BIT_TIMEOUT:BIT_POWER_DOWN]);
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("software changed read-only flags");

  property p_zero;
    fu_upd_z && !core_restore |=> live_q[BIT_Z] == ($past(fu_res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_half_add;
    alu_op == CCS_OP_ADD_REG && !core_restore
      |=> live_q[BIT_HALF_CARRY] == ($past({1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}) > 5'h0F);
  endproperty
  a_half_add: assert property (p_half_add) else $error("half-carry wrong on add");

  property p_carry_add;
    alu_op == CCS_OP_ADD_LIT && !core_restore
      |=> live_q[BIT_C] == $past(({1'b0, alu_a} + {1'b0, alu_b}) > 9'h0FF);
  endproperty
  a_carry_add: assert property (p_carry_add) else $error("carry wrong on add");

  property p_borrow;
    alu_op == CCS_OP_SUB_REG && !core_restore |=> live_q[BIT_C] == $past(alu_a >= alu_b);
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow polarity wrong");

  property p_rotate;
    alu_op == CCS_OP_RRC && !core_restore |=> live_q[BIT_C] == $past(alu_a[0]);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate carry wrong");

  property p_acc_write;
    wr_en && idx == IDX_ACC && pstrb[0] && !core_save |=> acc_cp_q == $past(pwdata[7:0]);
  endproperty
  a_acc_write: assert property (p_acc_write) else $error("accumulator copy not written");

  property p_bank_read;
    rd_setup && hit && idx == IDX_BANK |=> prdata_q[31:BANK_W] == 26'h0 && prdata_q[5:0] == $past(bank_cp_q);
  endproperty
  a_bank_read: assert property (p_bank_read) else $error("bank copy read wrong");

  property p_save_restore;
    core_save |=> restore_ptr1 == $past(core_ptr1) && restore_acc == $past(core_acc);
  endproperty
  a_save_restore: assert property (p_save_restore) else $error("restore does not return saved pointer");

  property p_restore_valid;
    core_restore |=> restore_valid;
  endproperty
  a_restore_valid: assert property (p_restore_valid) else $error("restore strobe missing");

  property p_restore_flags;
    core_restore |=> live_q[BIT_Z:BIT_C] == $past(flags_cp_q[BIT_Z:BIT_C]);
  endproperty
  a_restore_flags: assert property (p_restore_flags) else $error("flags not restored from copy");

  property p_save_flags;
    core_save |=> flags_cp_q == $past(live_q);
  endproperty
  a_save_flags: assert property (p_save_flags) else $error("flags not captured on save");

  property p_clear_wdt;
    wdt_clear && !wdt_timeout |=> live_q[BIT_TIMEOUT] && live_q[BIT_POWER_DOWN];
  endproperty
  a_clear_wdt: assert property (p_clear_wdt) else $error("watchdog clear did not set flags");

  property p_half_sub;
    alu_op == CCS_OP_SUB_LIT && !core_restore |=> live_q[BIT_HALF_CARRY] == $past(alu_a[3:0] >= alu_b[3:0]);
  endproperty
  a_half_sub: assert property (p_half_sub) else $error("half-carry wrong on subtract");

  property p_rotate_left;
    alu_op == CCS_OP_RLC && !core_restore |=> live_q[BIT_C] == $past(alu_a[ACC_W-1]);
  endproperty
  a_rotate_left: assert property (p_rotate_left) else $error("left rotate carry wrong");

  property p_ptr0_write;
    wr_en && idx == IDX_PTR0 && pstrb[1:0] == 2'h3 && !core_save |=> ptr0_cp_q == $past(pwdata[PTR_W-1:0]);
  endproperty
  a_ptr0_write: assert property (p_ptr0_write) else $error("pointer copy not written");

  property p_pcl_read;
    rd_setup && hit && idx == IDX_PCL |=> prdata_q[DATA_W-1:PCL_W] == 25'h0 && prdata_q[PCL_W-1:0] == $past(pcl_cp_q);
  endproperty
  a_pcl_read: assert property (p_pcl_read) else $error("latch copy read wrong");
endmodule : ccs_bank

// [bench/ccs_core_model.sv]
`timescale 1ns/1ns
// behavioural core: one alu op or one event pulse per call
module ccs_core_model (
  input wire logic pclk,
  output ccs_pkg::ccs_op_e alu_op,
  output logic [ccs_pkg::ACC_W-1:0] alu_a,
  output logic [ccs_pkg::ACC_W-1:0] alu_b,
  output logic wdt_clear,
  output logic sleep_instr,
  output logic wdt_timeout,
  output logic core_save,
  output logic core_restore,
  output logic [52:0] ctx
);
  import ccs_pkg::*;
  // idle core: no op, no events
  initial begin
    alu_op = CCS_OP_NONE;
    alu_a = 8'h00;
    alu_b = 8'h00;
    {core_restore, core_save, wdt_timeout, sleep_instr, wdt_clear} = 5'h00;
    ctx = 53'h0;
  end
  // operands may linger after the op; only alu_op says they matter
  task automatic op(input ccs_op_e o, input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    alu_op <= o;
    alu_a <= a;
    alu_b <= b;
    @(posedge pclk);
    alu_op <= CCS_OP_NONE;
  endtask : op
  // k is {restore, save, timeout, sleep, clear}; context flips afterwards so stale data never looks valid
  task automatic pulse(input logic [4:0] k, input logic [52:0] c);
    @(posedge pclk);
    {core_restore, core_save, wdt_timeout, sleep_instr, wdt_clear} <= k;
    ctx <= c;
    @(posedge pclk);
    {core_restore, core_save, wdt_timeout, sleep_instr, wdt_clear} <= 5'h00;
    ctx <= ~c;
  endtask : pulse
endmodule : ccs_core_model

// [bench/testbench.sv]
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
  import ccs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, perr, pready, pslverr, restore_valid;
  logic wdt_clear, sleep_instr, wdt_timeout, core_save, core_restore;
  logic [15:0] paddr, ba, restore_ptr0, restore_ptr1;
  logic [31:0] pwdata, prdata, v;
  logic [3:0] pstrb;
  ccs_op_e alu_op, o;
  logic [7:0] alu_a, alu_b, restore_acc, alu_result, a, b;
  logic [5:0] restore_bank;
  logic [6:0] restore_pcl;
  logic [4:0] live_flags, lf, fc;
  logic [12:0] ex;
  logic [52:0] ctx, cx;
  int err_count, samples_checked, i, p;
  ccs_core_model core (.pclk, .alu_op, .alu_a, .alu_b, .wdt_clear, .sleep_instr, .wdt_timeout,
    .core_save, .core_restore, .ctx);
  ccs_bank dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .alu_op, .alu_a, .alu_b, .wdt_clear, .sleep_instr, .wdt_timeout, .core_save,
    .core_acc(ctx[52:45]), .core_bank(ctx[44:39]), .core_pcl(ctx[38:32]), .core_ptr0(ctx[31:16]),
    .core_ptr1(ctx[15:0]), .core_restore, .restore_valid, .restore_acc, .restore_bank, .restore_pcl,
    .restore_ptr0, .restore_ptr1, .live_flags, .alu_result);
  // free-running core clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // one apb transfer; waits on pready rather than assuming the slave's latency
  task automatic apb(input logic w, input logic [15:0] ad, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    `CHK("pready", 1'b1, pready)
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [15:0] ad, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    apb(1'b1, ad, d, s, r);
  endtask : wr
  task automatic rd(input logic [15:0] ad, input logic [31:0] e, input logic ee);
    logic [31:0] r;
    apb(1'b0, ad, 32'h0, 4'h0, r);
    `CHK("prdata", e, r)
    `CHK("pslverr", ee, perr)
  endtask : rd
  task automatic chk_ctx(input logic [4:0] f);
    rd(16'h7F90, {27'h0, f}, 1'b0);
    rd(16'h7F94, {24'h0, cx[52:45]}, 1'b0);
    rd(16'h7F98, {26'h0, cx[44:39]}, 1'b0);
    rd(16'h7F9C, {25'h0, cx[38:32]}, 1'b0);
    rd(16'h7FA0, {16'h0, cx[31:16]}, 1'b0);
    rd(16'h7FA8, {16'h0, cx[15:0]}, 1'b0);
  endtask : chk_ctx
  // expected {result, flags}; subtraction adds the inverted operand plus one
  function automatic logic [12:0] calc(input ccs_op_e op, input logic [7:0] x, input logic [7:0] y,
    input logic [4:0] f);
    logic [8:0] s;
    logic [4:0] n;
    n = f;
    case (op)
      CCS_OP_ADD_REG, CCS_OP_ADD_LIT: begin
        s = {1'b0, x} + {1'b0, y};
        n[1] = ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0F;
      end
      CCS_OP_SUB_LIT, CCS_OP_SUB_REG: begin
        s = {1'b0, x} + {1'b0, ~y} + 9'h001;
        n[1] = ({1'b0, x[3:0]} + {1'b0, ~y[3:0]} + 5'h01) > 5'h0F;
      end
      CCS_OP_RRC: s = {x[0], f[0], x[7:1]};
      CCS_OP_RLC: s = {x[7], x[6:0], f[0]};
      default: s = {f[0], y};
    endcase
    n[0] = s[8];
    if (op != CCS_OP_RRC && op != CCS_OP_RLC) n[2] = (s[7:0] == 8'h00);
    return {s[7:0], n};
  endfunction : calc
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, perr} = 5'h00;
    paddr = 16'h0000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    void'($urandom(32'h49B096B6));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    lf = 5'h18;
    for (i = 0; i < 4; i++) begin
      v = $urandom;
      wr(16'h7F94, v, 4'h1);
      rd(16'h7F94, {24'h0, v[7:0]}, 1'b0);
      wr(16'h7F98, v, 4'h1);
      rd(16'h7F98, {26'h0, v[5:0]}, 1'b0);
      wr(16'h7F9C, v, 4'h1);
      rd(16'h7F9C, {25'h0, v[6:0]}, 1'b0);
      for (p = 0; p < 2; p++) begin
        ba = p ? 16'h7FA8 : 16'h7FA0;
        wr(ba, v, 4'h3);
        rd(ba, {16'h0, v[15:0]}, 1'b0);
        wr(ba + 16'h0004, v >> 24, 4'h1);
        rd(ba + 16'h0004, {24'h0, v[31:24]}, 1'b0);
        wr(ba, v >> 8, 4'h1);
        rd(ba, {16'h0, v[31:24], v[15:8]}, 1'b0);
      end
    end
    rd(16'h7FB0, 32'h0, 1'b1);
    rd(16'h7F95, 32'h0, 1'b1);
    for (i = 0; i < 40; i++) begin
      o = (i < 7) ? ccs_op_e'(i[2:0]) : ccs_op_e'($urandom_range(0, 6));
      a = 8'($urandom);
      b = 8'($urandom);
      if (i == 0) {a, b} = 16'hFF01;
      if (i == 2) {a, b} = 16'h5A5A;
      if (i == 3) {a, b} = 16'h1001;
      ex = calc(o, a, b, lf);
      lf = ex[4:0];
      core.op(o, a, b);
      #1;
      `CHK("live_flags", lf, live_flags)
      `CHK("alu_result", ex[12:5], alu_result)
    end
    // last pass fires all three events together: timeout must win
    for (i = 0; i < 5; i++) begin
      v[4:0] = (i == 0 || i == 3) ? 5'h04 : (i == 1) ? 5'h01 : (i == 2) ? 5'h02 : 5'h07;
      core.pulse(v[4:0], 53'h0);
      if (v[2]) lf[4] = 1'b0;
      else if (v[0]) lf[4:3] = 2'b11;
      else lf[4:3] = 2'b10;
      #1;
      `CHK("live_flags", lf, live_flags)
    end
    cx = 53'({$urandom, $urandom});
    core.pulse(5'h08, cx);
    v = $urandom;
    v[4:3] = ~lf[4:3];
    wr(16'h7F90, v, 4'h1);
    fc = {lf[4:3], v[2:0]};
    chk_ctx(fc);
    core.pulse(5'h10, ~cx);
    #1;
    `CHK("restore_valid", 1'b1, restore_valid)
    `CHK("restore", cx, {restore_acc, restore_bank, restore_pcl, restore_ptr0, restore_ptr1})
    `CHK("live_flags", fc, live_flags)
    @(posedge pclk);
    #1;
    `CHK("restore_valid", 1'b0, restore_valid)
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    `CHK("live_flags", 5'h18, live_flags)
    @(posedge pclk);
    presetn <= 1'b1;
    chk_ctx(fc);
    complete_run();
  end
endmodule : testbench
